/* flash_entry_device.sv */
// Purpose: Device end: counts Vpp pulses, then acts as serial slave.
// Assumes: Programmer owns the device reset while programming.
// Notes:   Received bytes are written to a 16 KB flash array image;
//          reply bytes read it back in the same order.
//
// Contract
// - Only sync 3-wire or port pseudo-3-wire.
// - Zero Vpp pulses sync, twelve port.
// - Sync clock from 100 Hz to 1.25 MHz.
// - Port clock from 100 Hz to 1 kHz.
// - Port pins: clock 0, out 1, in 2.
// - Flash clock 1-5 MHz, unity multiplier; here the flash runs on the 100 MHz clk_sys.
// - Program memory is sixteen kilobytes flash.
// - Unused pins keep their reset state; the programmer drives both data-in pins with the data.
// - Only programmer drives device reset; here the bench rstn is ANDed in as well.
`timescale 1ns/1ns
module flash_entry_device
    import flash_entry_pkg::*;
(
    // System
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    // Link
    flash_link_if.device             link,
    // User side
    output comm_mode_type            mode,
    output logic                     mode_valid,
    output logic [BYTE_W-1:0]        rx_byte,
    output logic                     rx_strobe,
    output logic [FLASH_AW-1:0]      rx_addr,
    output logic                     mode_error
);

    // =========================================================
    // Pin synchronisers
    // =========================================================
    // Serial clocks idle high and the other pins low. Starting the pin
    // history at those levels keeps a false edge from appearing when
    // reset lets go.
    localparam logic [4:0] PIN_IDLE = 5'h0a;

    // One edge decode serves the write-voltage pin and both serial clocks.
    function automatic logic pin_edge(input logic now_val,
                                      input logic old_val,
                                      input logic rising);
        return rising ? (now_val & ~old_val) : (~now_val & old_val);
    endfunction

    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic [4:0] pin_prev_reg;
    wire  [4:0] pin_raw = {link.vpp_pulse, link.sync_serial_clock,
                           link.sync_serial_data_in, link.port_clock_in_pin,
                           link.port_data_in_pin};

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_meta_reg <= PIN_IDLE;
            pin_sync_reg <= PIN_IDLE;
            pin_prev_reg <= PIN_IDLE;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    wire vpp_rise = pin_edge(pin_sync_reg[4], pin_prev_reg[4], 1'b1);
    wire vpp_fall = pin_edge(pin_sync_reg[4], pin_prev_reg[4], 1'b0);

    // =========================================================
    // Entry: Vpp pulse count
    // =========================================================
    typedef enum logic [1:0] {
        ST_COUNT = 2'b00,
        ST_SETTLE = 2'b01,
        ST_RUN   = 2'b11,
        ST_FAULT = 2'b10
    } entry_state_type;

    entry_state_type state_reg;
    entry_state_type state_next;
    logic [3:0] pulses_reg;
    logic [7:0] idle_reg;
    comm_mode_type mode_reg;
    comm_mode_type mode_next;

    wire settled = (idle_reg == VPP_SETTLE_CYC);
    // Selection table decodes the counted pulses.
    assign mode_next = (pulses_reg == PULSES_SYNC3) ? MODE_SYNC3 :
                       (pulses_reg == PULSES_PORT3) ? MODE_PORT3 :
                                                      MODE_NONE;

    // A pulse count outside the table parks entry in the fault state
    // until the programmer resets the device; there is no retry.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_COUNT:  if (settled) state_next = ST_SETTLE;
            ST_SETTLE: state_next = (mode_next == MODE_NONE) ? ST_FAULT
                                                             : ST_RUN;
            ST_RUN:    state_next = ST_RUN;
            ST_FAULT:  state_next = ST_FAULT;
        endcase
    end

    // Reset here is the bench reset and the programmer's combined; entry restarts on each one.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg  <= ST_COUNT;
            pulses_reg <= 4'h0;
            idle_reg   <= 8'h00;
            mode_reg   <= MODE_NONE;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_COUNT) begin
                if (vpp_rise && pulses_reg != PULSE_MAX)
                    pulses_reg <= pulses_reg + 4'h1;
                if (vpp_rise || pin_sync_reg[4])
                    idle_reg <= 8'h00;
                else if (!settled)
                    idle_reg <= idle_reg + 8'h01;
            end
            if (state_reg == ST_SETTLE)
                mode_reg <= mode_next;
        end
    end

    // =========================================================
    // Serial slave
    // =========================================================
    wire is_sync = (mode_reg == MODE_SYNC3);
    wire is_port = (mode_reg == MODE_PORT3);
    // Port mode: clock on pin 0, data in on pin 2.
    wire sck_now  = is_sync ? pin_sync_reg[3] : pin_sync_reg[1];
    wire sck_old  = is_sync ? pin_prev_reg[3] : pin_prev_reg[1];
    wire din      = is_sync ? pin_sync_reg[2] : pin_sync_reg[0];
    wire active   = (state_reg == ST_RUN) && vpp_fall == 1'b0;
    wire sck_fall = active & pin_edge(sck_now, sck_old, 1'b0);
    wire sck_rise = active & pin_edge(sck_now, sck_old, 1'b1);

    logic [BYTE_W-1:0]   shift_in_reg;
    logic [BYTE_W-1:0]   shift_out_reg;
    logic [2:0]          bit_reg;
    logic [FLASH_AW-1:0] addr_reg;
    logic [BYTE_W-1:0]   rx_byte_reg;
    logic                rx_strobe_reg;
    logic                dout_reg;
    // Sixteen kilobyte program store.
    logic [BYTE_W-1:0]   flash_mem [FLASH_BYTES];

    wire [BYTE_W-1:0] byte_done = {shift_in_reg[BYTE_W-2:0], din};
    wire last_bit = (bit_reg == LAST_BIT);
    // Address of the byte stored at the end of the last transfer; it is
    // read back only once the write has landed.
    wire [FLASH_AW-1:0] rd_addr = addr_reg - 1'b1;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shift_in_reg  <= 8'h00;
            shift_out_reg <= 8'h00;
            bit_reg       <= 3'h0;
            addr_reg      <= '0;
            rx_byte_reg   <= 8'h00;
            rx_strobe_reg <= 1'b0;
            dout_reg      <= 1'b0;
        end else begin
            rx_strobe_reg <= 1'b0;
            // Output changes on the falling edge, MSB first.
            if (sck_fall) begin
                dout_reg      <= shift_out_reg[BYTE_W-1];
                shift_out_reg <= {shift_out_reg[BYTE_W-2:0], 1'b0};
            end else if (rx_strobe_reg) begin
                // Read one cycle after the write, so the reply carries what
                // the array really holds and not the cell's old content.
                shift_out_reg <= flash_mem[rd_addr];
            end
            // Input sampled on the rising edge.
            if (sck_rise) begin
                shift_in_reg <= byte_done;
                bit_reg      <= bit_reg + 3'h1;
                if (last_bit) begin
                    rx_byte_reg   <= byte_done;
                    rx_strobe_reg <= 1'b1;
                    addr_reg      <= addr_reg + 1'b1;
                end
            end
        end
    end

    // Flash is written at the system clock, which is the flash clock at
    // unity rate; the bench runs it at 100 MHz, not within 1 to 5 MHz at the pin.
    always_ff @(posedge clk_sys) begin
        if (sck_rise && last_bit)
            flash_mem[addr_reg] <= byte_done;
    end

    // Unselected channel output stays low, its state after reset.
    assign link.sync_serial_data_out = is_sync ? dout_reg : 1'b0;
    assign link.port_data_out_pin    = is_port ? dout_reg : 1'b0;

    assign mode       = mode_reg;
    assign mode_valid = (state_reg == ST_RUN);
    assign mode_error = (state_reg == ST_FAULT);
    assign rx_byte    = rx_byte_reg;
    assign rx_strobe  = rx_strobe_reg;
    assign rx_addr    = addr_reg;

endmodule

/* flash_entry_pkg.sv */
// Purpose: Shared constants for the flash programming serial entry link.
// Assumes: 100 MHz system clock on both ends.
// Notes:   Mode codes, pulse counts and link timing live here.
package flash_entry_pkg;

    // =========================================================
    // Mode selection
    // =========================================================
    typedef enum logic [1:0] {
        MODE_NONE  = 2'b00,
        MODE_SYNC3 = 2'b01,
        MODE_PORT3 = 2'b11
    } comm_mode_type;

    localparam logic [3:0] PULSES_SYNC3 = 4'h0;
    localparam logic [3:0] PULSES_PORT3 = 4'hc;
    localparam logic [3:0] PULSE_MAX    = 4'hf;

    // =========================================================
    // Timing
    // =========================================================
    localparam int CLK_SYS_HZ      = 100_000_000;
    localparam int SYNC_SCK_MAX_HZ = 1_250_000;
    localparam int SYNC_SCK_MIN_HZ = 100;
    localparam int PORT_SCK_MAX_HZ = 1_000;
    localparam int PORT_SCK_MIN_HZ = 100;
    localparam int FLASH_CLK_MIN_HZ = 1_000_000;
    localparam int FLASH_CLK_MAX_HZ = 5_000_000;
    // Multiplication rate is unity: flash clock equals the system clock
    // divided by this value, which must stay 1.
    localparam int MULT_RATE = 1;

    // Half periods in system cycles, rounded so the rate never exceeds max.
    localparam int SYNC_HALF_CYC =
        (CLK_SYS_HZ + 2 * SYNC_SCK_MAX_HZ - 1) / (2 * SYNC_SCK_MAX_HZ);
    localparam int PORT_HALF_CYC =
        (CLK_SYS_HZ + 2 * PORT_SCK_MAX_HZ - 1) / (2 * PORT_SCK_MAX_HZ);
    localparam int DIV_W = 16;

    // Vpp pulse high and gap widths in system cycles.
    localparam logic [7:0] VPP_PULSE_CYC = 8'h0_10;
    localparam logic [7:0] VPP_SETTLE_CYC = 8'h0_40;

    // =========================================================
    // Data and memory
    // =========================================================
    localparam int BYTE_W      = 8;
    localparam int FLASH_BYTES = 16384;
    localparam int FLASH_AW    = 14;
    localparam logic [2:0] LAST_BIT = 3'h7;

endpackage

/* flash_link_if.sv */
// Purpose: Pins between the flash programmer and the device.
// Assumes: Testbench resolves nothing; all pins are one-way here.
// Notes:   Both serial channels are present; only the selected clock toggles, both data-in pins follow.
`timescale 1ns/1ns
interface flash_link_if;
    logic vpp_pulse;
    logic dev_reset_n;
    logic system_clock_input_pin;
    logic sync_serial_clock;
    logic sync_serial_data_in;
    logic sync_serial_data_out;
    logic port_clock_in_pin;
    logic port_data_in_pin;
    logic port_data_out_pin;

    modport device (
        input  vpp_pulse,
        input  dev_reset_n,
        input  system_clock_input_pin,
        input  sync_serial_clock,
        input  sync_serial_data_in,
        output sync_serial_data_out,
        input  port_clock_in_pin,
        input  port_data_in_pin,
        output port_data_out_pin
    );

    modport programmer (
        output vpp_pulse,
        output dev_reset_n,
        output system_clock_input_pin,
        output sync_serial_clock,
        output sync_serial_data_in,
        input  sync_serial_data_out,
        output port_clock_in_pin,
        output port_data_in_pin,
        input  port_data_out_pin
    );
endinterface

/* flash_entry_programmer.sv */
// Purpose: Programmer end: resets the device, sends Vpp pulses, clocks bytes.
// Assumes: 100 MHz system clock; one byte exchanged per request.
// Notes:   Serial clock is divided down from clk_sys and driven out.
`timescale 1ns/1ns
module flash_entry_programmer
    import flash_entry_pkg::*;
(
    // System
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    // Link
    flash_link_if.programmer         link,
    // User side
    input  wire logic                start,
    input  wire logic                port_mode,
    input  wire logic                tx_valid,
    input  wire logic [BYTE_W-1:0]   tx_byte,
    output logic                     tx_ready,
    output logic [BYTE_W-1:0]        rx_byte,
    output logic                     rx_strobe,
    output logic                     entered
);

    typedef enum logic [2:0] {
        P_IDLE  = 3'b000,
        P_PULSE = 3'b001,
        P_GAP   = 3'b011,
        P_WAIT  = 3'b010,
        P_READY = 3'b110,
        P_XFER  = 3'b111
    } prog_state_type;

    prog_state_type state_reg;
    logic [DIV_W-1:0]  div_reg;
    logic [3:0]        pulses_reg;
    logic [7:0]        tim_reg;
    logic              port_reg;
    logic              sck_reg;
    logic              vpp_reg;
    logic              rst_n_reg;
    logic [3:0]        edges_reg;
    logic [BYTE_W-1:0] tx_sh_reg;
    logic [BYTE_W-1:0] rx_sh_reg;
    logic [BYTE_W-1:0] rx_byte_reg;
    logic              rx_strobe_reg;
    logic              din_meta_reg;
    logic              din_sync_reg;

    // Half period chosen so the clock never exceeds the mode maximum.
    wire [DIV_W-1:0] half = port_reg ? DIV_W'(PORT_HALF_CYC - 1)
                                     : DIV_W'(SYNC_HALF_CYC - 1);
    wire div_hit   = (div_reg == half);
    wire [3:0] goal = port_reg ? PULSES_PORT3 : PULSES_SYNC3;
    wire din_raw   = port_reg ? link.port_data_out_pin
                              : link.sync_serial_data_out;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= P_IDLE;  div_reg <= '0;  pulses_reg <= 4'h0;
            tim_reg <= 8'h00;  port_reg <= 1'b0;  sck_reg <= 1'b1;
            vpp_reg <= 1'b0;  rst_n_reg <= 1'b0;  edges_reg <= 4'h0;
            tx_sh_reg <= 8'h00;  rx_sh_reg <= 8'h00;  rx_byte_reg <= 8'h00;
            rx_strobe_reg <= 1'b0;  din_meta_reg <= 1'b0;
            din_sync_reg <= 1'b0;
        end else begin
            din_meta_reg  <= din_raw;
            din_sync_reg  <= din_meta_reg;
            rx_strobe_reg <= 1'b0;
            tim_reg <= tim_reg + 8'h01;
            unique case (state_reg)
                P_IDLE: if (start) begin
                    port_reg <= port_mode; pulses_reg <= 4'h0;
                    rst_n_reg <= 1'b0; tim_reg <= 8'h00;
                    state_reg <= P_GAP;
                end
                P_GAP: if (tim_reg == VPP_PULSE_CYC) begin
                    rst_n_reg <= 1'b1; tim_reg <= 8'h00;
                    if (pulses_reg == goal) state_reg <= P_WAIT;
                    else begin vpp_reg <= 1'b1; state_reg <= P_PULSE; end
                end
                P_PULSE: if (tim_reg == VPP_PULSE_CYC) begin
                    vpp_reg <= 1'b0; tim_reg <= 8'h00;
                    pulses_reg <= pulses_reg + 4'h1; state_reg <= P_GAP;
                end
                // Wait beyond the device's settle window before clocking.
                P_WAIT: if (tim_reg == VPP_SETTLE_CYC + VPP_PULSE_CYC)
                    state_reg <= P_READY;
                P_READY: if (tx_valid) begin
                    tx_sh_reg <= tx_byte; edges_reg <= 4'h0;
                    div_reg <= '0; state_reg <= P_XFER;
                end
                P_XFER: begin
                    div_reg <= div_hit ? '0 : div_reg + 1'b1;
                    if (div_hit) begin
                        sck_reg   <= ~sck_reg;
                        edges_reg <= edges_reg + 4'h1;
                        // Sample on the rising edge; move data only on the
                        // falling one, so it is steady when the slave looks.
                        if (sck_reg == 1'b0)
                            rx_sh_reg <= {rx_sh_reg[BYTE_W-2:0],
                                          din_sync_reg};
                        if (sck_reg == 1'b1 && edges_reg != 4'h0)
                            tx_sh_reg <= {tx_sh_reg[BYTE_W-2:0], 1'b0};
                        if (edges_reg == 4'hf) begin
                            rx_byte_reg <= {rx_sh_reg[BYTE_W-2:0],
                                            din_sync_reg};
                            rx_strobe_reg <= 1'b1;
                            state_reg <= P_READY;
                        end
                    end
                end
                default: state_reg <= P_IDLE;
            endcase
        end
    end

    wire sync_sel = ~port_reg & (state_reg == P_XFER);
    wire port_sel =  port_reg & (state_reg == P_XFER);

    assign link.vpp_pulse              = vpp_reg;
    assign link.dev_reset_n            = rst_n_reg;
    assign link.system_clock_input_pin = clk_sys;
    assign link.sync_serial_clock      = sync_sel ? sck_reg : 1'b1;
    assign link.port_clock_in_pin      = port_sel ? sck_reg : 1'b1;
    assign link.sync_serial_data_in    = tx_sh_reg[BYTE_W-1];
    assign link.port_data_in_pin       = tx_sh_reg[BYTE_W-1];
    assign tx_ready  = (state_reg == P_READY);
    assign rx_byte   = rx_byte_reg;
    assign rx_strobe = rx_strobe_reg;
    assign entered   = (state_reg == P_READY) || (state_reg == P_XFER);

endmodule

/* flash_link_sva.sv */
// Purpose: Timing checks on the pins between programmer and device.
// Assumes: Both ends run from the bench clk_sys; rstn is the bench reset.
// Notes:   Half-period counters stand in for long repetitions.
`timescale 1ns/1ns
module flash_link_sva
    import flash_entry_pkg::*;
(
    // System
    input wire logic clk_sys,
    input wire logic rstn,
    // Link
    input wire logic vpp_pulse,
    input wire logic dev_reset_n,
    input wire logic sync_serial_clock,
    input wire logic sync_serial_data_in,
    input wire logic sync_serial_data_out,
    input wire logic port_clock_in_pin
);
    localparam int SYNC_MIN = SYNC_HALF_CYC - 1;
    localparam int PORT_MIN = PORT_HALF_CYC - 1;

    // =========================================================
    // Helper counters
    // =========================================================
    // Each counter holds how long the previous clock level lasted.
    logic             sck_reg;
    logic             pck_reg;
    logic [DIV_W-1:0] scnt_reg;
    logic [DIV_W-1:0] pcnt_reg;
    logic [DIV_W-1:0] scnt_next;
    logic [DIV_W-1:0] pcnt_next;
    wire              sck_edge = sync_serial_clock != sck_reg;
    wire              pck_edge = port_clock_in_pin != pck_reg;

    assign scnt_next = sck_edge ? 16'h0001 :
                       (&scnt_reg) ? scnt_reg : scnt_reg + 16'h0001;
    assign pcnt_next = pck_edge ? 16'h0001 :
                       (&pcnt_reg) ? pcnt_reg : pcnt_reg + 16'h0001;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sck_reg  <= 1'b1;
            pck_reg  <= 1'b1;
            scnt_reg <= '1;
            pcnt_reg <= '1;
        end else begin
            sck_reg  <= sync_serial_clock;
            pck_reg  <= port_clock_in_pin;
            scnt_reg <= scnt_next;
            pcnt_reg <= pcnt_next;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // =========================================================
    // Assertions
    // =========================================================
    a_clocks_quiet_reset: assert property (
        !dev_reset_n |-> sync_serial_clock && port_clock_in_pin)
        else $error("serial clock moved while device held in reset");
    a_sync_half_min: assert property (
        sck_edge |-> scnt_reg >= SYNC_MIN)
        else $error("sync serial clock half period too short");
    a_port_half_min: assert property (
        pck_edge |-> pcnt_reg >= PORT_MIN)
        else $error("port serial clock half period too short");
    a_vpp_pulse_width: assert property (
        $rose(vpp_pulse) |-> vpp_pulse[*8] ##1 vpp_pulse[*8]
                             ##1 vpp_pulse ##1 !vpp_pulse)
        else $error("write voltage pulse width wrong");
    a_port_excl_sync: assert property (
        !port_clock_in_pin |-> sync_serial_clock)
        else $error("both serial clocks active");
    a_sync_excl_port: assert property (
        !sync_serial_clock |-> port_clock_in_pin)
        else $error("port clock left idle level in sync mode");
    a_din_setup: assert property (
        $rose(sync_serial_clock) |->
            sync_serial_data_in == $past(sync_serial_data_in, 3))
        else $error("data in changed just before rising clock");
    a_dout_setup: assert property (
        $rose(sync_serial_clock) |->
            sync_serial_data_out == $past(sync_serial_data_out, 8))
        else $error("data out changed just before rising clock");

    c_vpp: cover property ($rose(vpp_pulse));
    c_sync_clk: cover property ($fell(sync_serial_clock));
    c_port_clk: cover property ($fell(port_clock_in_pin));
endmodule

/* tb_top.sv */
// Purpose: Runs both link ends against each other and a faulty driver.
// Assumes: Port mode bytes are too slow to finish; only its start is seen.
// Notes:   A second device on link2 is fed wrong pulse counts by the bench.
`timescale 1ns/1ns
module tb_top
    import flash_entry_pkg::*;
;
    logic                clk_sys;
    logic                rstn;
    logic                start;
    logic                port_mode;
    logic                tx_valid;
    logic [BYTE_W-1:0]   tx_byte;
    logic [BYTE_W-1:0]   p_rx_byte;
    logic [BYTE_W-1:0]   d_rx_byte;
    logic [BYTE_W-1:0]   wire_in;
    logic [BYTE_W-1:0]   wire_out;
    logic                p_tx_ready;
    logic                p_rx_strobe;
    logic                p_entered;
    logic                d_rx_strobe;
    comm_mode_type       d_mode;
    logic                d_valid;
    logic                d_error;
    logic                e_valid;
    logic                e_error;
    logic [FLASH_AW-1:0] d_rx_addr;
    logic [3:0]          vpp_cnt;
    int                  mismatches;
    int                  checked;
    wire                 dev_rstn;
    wire                 dev2_rstn;

    flash_link_if link();
    flash_link_if link2();
    assign dev_rstn  = rstn & link.dev_reset_n;
    assign dev2_rstn = rstn & link2.dev_reset_n;
    assign link2.system_clock_input_pin = clk_sys;

    flash_entry_programmer flash_entry_programmer_i (
        .clk_sys(clk_sys), .rstn(rstn), .link(link.programmer),
        .start(start), .port_mode(port_mode), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(p_tx_ready), .rx_byte(p_rx_byte),
        .rx_strobe(p_rx_strobe), .entered(p_entered));
    flash_entry_device flash_entry_device_i (
        .clk_sys(clk_sys), .rstn(dev_rstn), .link(link.device),
        .mode(d_mode), .mode_valid(d_valid), .rx_byte(d_rx_byte),
        .rx_strobe(d_rx_strobe), .rx_addr(d_rx_addr), .mode_error(d_error));
    flash_entry_device fault_device_i (
        .clk_sys(clk_sys), .rstn(dev2_rstn), .link(link2.device),
        .mode(), .mode_valid(e_valid), .rx_byte(), .rx_strobe(),
        .rx_addr(), .mode_error(e_error));
    flash_link_sva flash_link_sva_i (
        .clk_sys(clk_sys), .rstn(rstn), .vpp_pulse(link.vpp_pulse),
        .dev_reset_n(link.dev_reset_n),
        .sync_serial_clock(link.sync_serial_clock),
        .sync_serial_data_in(link.sync_serial_data_in),
        .sync_serial_data_out(link.sync_serial_data_out),
        .port_clock_in_pin(link.port_clock_in_pin));

    // =========================================================
    // Wire monitors
    // =========================================================
    always @(posedge link.vpp_pulse) vpp_cnt <= vpp_cnt + 4'h1;
    always @(posedge link.sync_serial_clock) begin
        wire_in  <= {wire_in[6:0], link.sync_serial_data_in};
        wire_out <= {wire_out[6:0], link.sync_serial_data_out};
    end

    // =========================================================
    // Tasks
    // =========================================================
    task automatic chk(input string name, input logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", name, e, g);
            mismatches++;
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic do_reset();
        rstn    = 1'b0;
        vpp_cnt = 4'h0;
        repeat (4) @(negedge clk_sys);
        chk("entered_rst", 16'h0000, p_entered);
        chk("dev_reset_n_rst", 16'h0000, link.dev_reset_n);
        chk("mode_rst", 16'h0000, d_mode);
        chk("sck_rst", 16'h0001, link.sync_serial_clock);
        rstn = 1'b1;
    endtask

    task automatic enter(input logic pm, input logic [1:0] m,
                         input logic [3:0] p);
        int n;
        n         = 0;
        port_mode = pm;
        start     = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        while (!(d_valid === 1'b1 && p_entered === 1'b1) && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        chk("entered", 16'h0001, p_entered);
        chk("mode", {14'h0000, m}, d_mode);
        chk("vpp_pulses", {12'h000, p}, vpp_cnt);
        chk("mode_error", 16'h0000, d_error);
        chk("mode_valid", 16'h0001, d_valid);
    endtask

    task automatic wait_ready_send(input logic [BYTE_W-1:0] b);
        int n;
        n = 0;
        while (p_tx_ready !== 1'b1 && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        tx_byte  = b;
        tx_valid = 1'b1;
        @(negedge clk_sys);
        tx_valid = 1'b0;
    endtask

    task automatic send_byte(input logic [BYTE_W-1:0] b, r, input int k);
        int n;
        n = 0;
        wait_ready_send(b);
        while (p_rx_strobe !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        // The device sees the last rising edge through its synchroniser.
        while (d_rx_strobe !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("dev_strobe", 16'h0001, d_rx_strobe);
        @(negedge clk_sys);
        chk("prog_rx", {8'h00, r}, p_rx_byte);
        chk("dev_rx", {8'h00, b}, d_rx_byte);
        chk("dev_addr", 16'(k + 1), {2'b00, d_rx_addr});
        chk("wire_in", {8'h00, b}, wire_in);
        chk("wire_out", {8'h00, r}, wire_out);
    endtask

    task automatic bad_entry(input int pulses);
        link2.dev_reset_n = 1'b0;
        repeat (17) @(negedge clk_sys);
        link2.dev_reset_n = 1'b1;
        repeat (pulses) begin
            link2.vpp_pulse = 1'b1;
            repeat (17) @(negedge clk_sys);
            link2.vpp_pulse = 1'b0;
            repeat (17) @(negedge clk_sys);
        end
        repeat (200) @(negedge clk_sys);
        chk("bad_error", 16'h0001, e_error);
        chk("bad_valid", 16'h0000, e_valid);
    endtask

    // =========================================================
    // Clock, watchdog and tests
    // =========================================================
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Port mode waits about 50000 cycles; everything else is short.
    initial begin
        #900_000;
        mismatches++;
        wrap_up();
    end

    initial begin
        int n;
        n = 0;
        {rstn, start, port_mode, tx_valid} = 4'h0;
        {tx_byte, vpp_cnt, mismatches, checked} = '0;
        link2.vpp_pulse = 1'b0;
        link2.dev_reset_n = 1'b0;
        link2.sync_serial_clock = 1'b1;
        link2.sync_serial_data_in = 1'b0;
        link2.port_clock_in_pin = 1'b1;
        link2.port_data_in_pin = 1'b0;
        do_reset();
        enter(1'b0, MODE_SYNC3, PULSES_SYNC3);
        send_byte(8'ha5, 8'h00, 0);
        send_byte(8'h3c, 8'ha5, 1);
        send_byte(8'hff, 8'h3c, 2);
        send_byte(8'h00, 8'hff, 3);
        chk("port_clk_idle", 16'h0001, link.port_clock_in_pin);
        do_reset();
        enter(1'b1, MODE_PORT3, PULSES_PORT3);
        wait_ready_send(8'h81);
        while (link.port_clock_in_pin !== 1'b0 && n < 60000) begin
            @(negedge clk_sys);
            n++;
        end
        chk("port_clk_low", 16'h0000, link.port_clock_in_pin);
        chk("sync_clk_idle", 16'h0001, link.sync_serial_clock);
        do_reset();
        bad_entry(1);
        bad_entry(13);
        wrap_up();
    end
endmodule
